// ---- cslt_pkg.sv ----
// constants of the card slot timing and interrupt block
// assumes a 32-bit AXI4-Lite register port with full byte addresses
package cslt_pkg;
  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [31:0] ADDR_SLOT_CFG = 32'h4B80_1820;
  localparam logic [31:0] ADDR_IRQ      = 32'h4B80_1824;
  localparam logic [31:0] ADDR_ATTR_TIM = 32'h4B80_1828;
  localparam logic [31:0] ADDR_IO_TIM   = 32'h4B80_182C;
  localparam logic [31:0] ADDR_COMM_TIM = 32'h4B80_1830;
  localparam logic [31:0] ADDR_DISK_CTL = 32'h4B80_1900;

  // ****************************************************************
  // reset values and writable masks
  // ****************************************************************
  localparam logic [31:0] RST_IRQ      = 32'h0000_0600;
  localparam logic [31:0] RST_TIM      = 32'h0003_1909;
  localparam logic [31:0] RST_DISK_CTL = 32'h0000_0002;
  localparam logic [31:0] RST_SLOT_CFG = 32'h0000_0F00;
  localparam logic [31:0] MASK_TIM     = 32'h007F_7F7F;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int MASK_LSB      = 8;  // masks at 10:8, pending at 2:0
  localparam int SETUP_LSB     = 0;
  localparam int STROBE_LSB    = 8;
  localparam int HOLD_LSB      = 16;
  localparam int LEN_W         = 7;
  localparam int IO_WIDE_BIT   = 8;
  localparam int COMM_WIDE_BIT = 9;
  localparam int ATTR_WIDE_BIT = 10;
  localparam int WAIT_HON_BIT  = 11;
  localparam int ENABLE_BIT    = 0;
  localparam int CLKDN_BIT     = 1;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    REG_CFG = 3'h0, REG_IRQ = 3'h1, REG_ATTR = 3'h2, REG_IO = 3'h3,
    REG_COMM = 3'h4, REG_DISK = 3'h5, REG_NONE = 3'h7
  } cslt_reg_t;
  typedef enum logic [1:0] {
    SP_ATTR = 2'h0, SP_IO = 2'h1, SP_COMM = 2'h2
  } cslt_space_t;
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0, PH_SETUP = 2'h1, PH_STROBE = 2'h2, PH_HOLD = 2'h3
  } cslt_phase_t;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- cslt_acc_if.sv ----
// carrier between the register block and the access sequencer
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface cslt_acc_if;
  logic                          start;
  logic [cslt_pkg::LEN_W-1:0]    setup_len;
  logic [cslt_pkg::LEN_W-1:0]    strobe_len;
  logic [cslt_pkg::LEN_W-1:0]    hold_len;
  logic                          wide;
  logic                          wait_honour;
  logic                          wait_n;
  logic                          busy;
  logic                          done;
  logic                          strobe_n;
  logic                          wide_out;
  cslt_pkg::cslt_phase_t         phase;
  modport ctrl (output start, setup_len, strobe_len, hold_len, wide, wait_honour, wait_n,
                input busy, done, strobe_n, wide_out, phase);
  modport seq  (input start, setup_len, strobe_len, hold_len, wide, wait_honour, wait_n,
                output busy, done, strobe_n, wide_out, phase);
endinterface
`default_nettype wire

// ---- cslt_sync.sv ----
// two-stage synchroniser for pins from outside the clock domain
// assumes inputs are quasi-static levels; only the second stage is read
`timescale 1ns/1ps
`default_nettype none
module cslt_sync #(
  parameter int          W   = 3,
  parameter logic [W-1:0] RST = '1
) (
  // clock and control
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // levels
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  logic [W-1:0] meta_q;

  // stage one feeds stage two and nothing else
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RST;
      q      <= RST;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ---- cslt_seq.sv ----
// card access sequencer: setup, strobe and hold phases
// assumes start is a one-cycle pulse given only while busy is low
`timescale 1ns/1ps
`default_nettype none
module cslt_seq (
  // clock and control
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // link to the register block
  cslt_acc_if.seq   acc
);
  cslt_pkg::cslt_phase_t           ph_q, ph_d;
  logic [cslt_pkg::LEN_W-1:0]      cnt_q, cnt_d, len_w;
  logic [3*cslt_pkg::LEN_W-1:0]    lens_q;
  logic                            last_w, stall_w;

  // lengths are latched at start so a timing register write cannot stretch an access
  assign len_w   = (ph_q == cslt_pkg::PH_SETUP)  ? lens_q[0 +: cslt_pkg::LEN_W] :
                   (ph_q == cslt_pkg::PH_STROBE) ? lens_q[cslt_pkg::LEN_W +: cslt_pkg::LEN_W] :
                                                   lens_q[2*cslt_pkg::LEN_W +: cslt_pkg::LEN_W];
  assign stall_w = (ph_q == cslt_pkg::PH_STROBE) & acc.wait_honour & ~acc.wait_n;
  assign last_w  = (cnt_q == len_w) & ~stall_w;

  // phase order setup, strobe, hold
  always_comb begin
    ph_d  = ph_q;
    cnt_d = last_w ? '0 : cnt_q + 7'h01;
    case (ph_q)
      cslt_pkg::PH_IDLE: begin
        cnt_d = '0;
        if (acc.start) ph_d = cslt_pkg::PH_SETUP;
      end
      cslt_pkg::PH_SETUP:  if (last_w) ph_d = cslt_pkg::PH_STROBE;
      cslt_pkg::PH_STROBE: begin
        if (stall_w) cnt_d = cnt_q;
        if (last_w) ph_d = cslt_pkg::PH_HOLD;
      end
      cslt_pkg::PH_HOLD:   if (last_w) ph_d = cslt_pkg::PH_IDLE;
      default:             ph_d = cslt_pkg::PH_IDLE;
    endcase
  end

  // state and registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_q         <= cslt_pkg::PH_IDLE;
      cnt_q        <= '0;
      lens_q       <= '0;
      acc.busy     <= 1'b0;
      acc.done     <= 1'b0;
      acc.strobe_n <= 1'b1;
      acc.wide_out <= 1'b1;
    end else if (ce) begin
      ph_q         <= ph_d;
      cnt_q        <= cnt_d;
      acc.busy     <= (ph_d != cslt_pkg::PH_IDLE);
      acc.done     <= (ph_q == cslt_pkg::PH_HOLD) & last_w;
      acc.strobe_n <= (ph_d != cslt_pkg::PH_STROBE);
      if (acc.start && ph_q == cslt_pkg::PH_IDLE) begin
        lens_q       <= {acc.hold_len, acc.strobe_len, acc.setup_len};
        acc.wide_out <= acc.wide;
      end
    end
  end
  assign acc.phase = ph_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_phase_end;
    @(posedge clk) disable iff (rst)
      (ce && ph_q == cslt_pkg::PH_SETUP && cnt_q == lens_q[6:0]) |=> ph_q == cslt_pkg::PH_STROBE;
  endproperty
  a_phase_end: assert property (p_phase_end) else $error("setup did not end at its length");
  property p_wait_hold;
    @(posedge clk) disable iff (rst)
      (ce && stall_w) |=> (ph_q == cslt_pkg::PH_STROBE && $stable(cnt_q));
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("strobe left while card waited");
  property p_order;
    @(posedge clk) disable iff (rst)
      (ce && ph_q == cslt_pkg::PH_IDLE && acc.start) |=> ph_q == cslt_pkg::PH_SETUP;
  endproperty
  a_order: assert property (p_order) else $error("access did not open with setup");
  c_wait: cover property (@(posedge clk) disable iff (rst) ce && stall_w);
endmodule
`default_nettype wire

// ---- cslt_top.sv ----
// card slot timing, interrupt and disk host power control, AXI4-Lite slave
// assumes card pins are asynchronous; disk_host_idle and acc_req are on clk
`timescale 1ns/1ps
`default_nettype none
module cslt_top (
  // clock and control
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // axi4-lite write channels
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read channels
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // card pins
  input  wire logic        card_detect_in_n,
  input  wire logic        card_irq_in_n,
  input  wire logic        card_wait_in_n,
  output logic             card_strobe_n,
  output logic             card_wide,
  // access request port
  input  wire logic        acc_req,
  input  wire logic [1:0]  acc_space,
  output logic             acc_busy,
  output logic             acc_done,
  // disk host and interrupt
  input  wire logic        disk_host_idle,
  output logic             disk_host_enable,
  output logic             card_irq_out
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic cslt_pkg::cslt_reg_t reg_index(input logic [31:0] a);
    case (a)
      cslt_pkg::ADDR_SLOT_CFG: reg_index = cslt_pkg::REG_CFG;
      cslt_pkg::ADDR_IRQ:      reg_index = cslt_pkg::REG_IRQ;
      cslt_pkg::ADDR_ATTR_TIM: reg_index = cslt_pkg::REG_ATTR;
      cslt_pkg::ADDR_IO_TIM:   reg_index = cslt_pkg::REG_IO;
      cslt_pkg::ADDR_COMM_TIM: reg_index = cslt_pkg::REG_COMM;
      cslt_pkg::ADDR_DISK_CTL: reg_index = cslt_pkg::REG_DISK;
      default:                 reg_index = cslt_pkg::REG_NONE;
    endcase
  endfunction

  // byte-lane merge of write data into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      if (st[i]) old[8*i +: 8] = wd[8*i +: 8];
    end
    merge = old;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic        aw_have_q, w_have_q;
  logic [31:0] aw_addr_q, w_data_q;
  logic [3:0]  w_strb_q;
  logic [2:0]  mask_q, pend_q, pend_d, pend_set, pend_clr;
  logic [31:0] attr_tim_q, io_tim_q, comm_tim_q;
  logic [3:0]  cfg_q;            // wait honour, attr, common, io wide
  logic        clk_down_ready_q;
  logic [2:0]  pins_s, pins_d1_q; // detect, request, wait (all active low)
  logic        cd_fall, irq_fall, card_present, acc_start, empty_err;
  logic        wr_fire, ar_fire;
  cslt_pkg::cslt_reg_t wr_idx, rd_idx;
  logic [31:0] wr_new, rd_word, irq_word, tim_sel;
  logic [31:0] cfg_merged, irq_merged;
  cslt_acc_if  acc ();

  // ****************************************************************
  // pin synchronisers and edges
  // ****************************************************************
  cslt_sync #(.W(3), .RST(3'h7)) u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   ({card_wait_in_n, card_irq_in_n, card_detect_in_n}),
    .q   (pins_s)
  );

  // previous synchronised level, for edge detection
  always_ff @(posedge clk) begin
    if (rst) pins_d1_q <= 3'h7;
    else if (ce) pins_d1_q <= pins_s;
  end

  // insertion and request are falling edges of active-low levels
  assign cd_fall      = pins_d1_q[0] & ~pins_s[0];
  assign irq_fall     = pins_d1_q[1] & ~pins_s[1];
  assign card_present = ~pins_s[0];

  // ****************************************************************
  // access launch
  // ****************************************************************
  // a request with no card raises an error and never reaches the card
  assign empty_err = acc_req & ~acc.busy & ~card_present;
  assign acc_start = acc_req & ~acc.busy & card_present;
  assign tim_sel   = (acc_space == cslt_pkg::SP_ATTR) ? attr_tim_q :
                     (acc_space == cslt_pkg::SP_IO)   ? io_tim_q   :
                                                        comm_tim_q;

  assign acc.start       = acc_start;
  assign acc.setup_len   = tim_sel[cslt_pkg::SETUP_LSB  +: cslt_pkg::LEN_W];
  assign acc.strobe_len  = tim_sel[cslt_pkg::STROBE_LSB +: cslt_pkg::LEN_W];
  assign acc.hold_len    = tim_sel[cslt_pkg::HOLD_LSB   +: cslt_pkg::LEN_W];
  assign acc.wide        = (acc_space == cslt_pkg::SP_ATTR) ? cfg_q[2] :
                           (acc_space == cslt_pkg::SP_IO)   ? cfg_q[0] : cfg_q[1];
  assign acc.wait_honour = cfg_q[3];
  assign acc.wait_n      = pins_s[2];

  cslt_seq u_seq (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .acc (acc.seq)
  );

  assign card_strobe_n = acc.strobe_n;
  assign card_wide     = acc.wide_out;
  assign acc_busy      = acc.busy;
  assign acc_done      = acc.done;

  // ****************************************************************
  // register bus decode
  // ****************************************************************
  assign wr_fire  = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign ar_fire  = s_axi_arvalid & s_axi_arready;
  assign wr_idx   = reg_index(aw_addr_q);
  assign rd_idx   = reg_index(s_axi_araddr);
  assign irq_word = {21'h0, mask_q, 5'h0, pend_q};
  assign rd_word  = (rd_idx == cslt_pkg::REG_CFG)  ? {20'h0, cfg_q, 5'h0, pins_s} :
                    (rd_idx == cslt_pkg::REG_IRQ)  ? irq_word :
                    (rd_idx == cslt_pkg::REG_ATTR) ? attr_tim_q :
                    (rd_idx == cslt_pkg::REG_IO)   ? io_tim_q :
                    (rd_idx == cslt_pkg::REG_COMM) ? comm_tim_q :
                    (rd_idx == cslt_pkg::REG_DISK) ?
                      {30'h0, clk_down_ready_q, disk_host_enable} : 32'h0;
  assign wr_new   = merge(32'h0, w_data_q, w_strb_q);
  // old word merged with the write, so a lane left out keeps its bits
  assign cfg_merged = merge({20'h0, cfg_q, 8'h0}, w_data_q, w_strb_q);
  assign irq_merged = merge(irq_word, w_data_q, w_strb_q);

  // pending: set wins over a write-one clear in the same cycle
  assign pend_set = {empty_err, irq_fall, cd_fall};
  assign pend_clr = (wr_fire && wr_idx == cslt_pkg::REG_IRQ) ? wr_new[2:0] : 3'h0;
  assign pend_d   = (pend_q & ~pend_clr) | pend_set;

  // ****************************************************************
  // axi channel handshakes
  // ****************************************************************
  // address and data are caught apart and the write runs once both are held
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 32'h0;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= cslt_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_idx == cslt_pkg::REG_NONE) ? cslt_pkg::RESP_SLVERR
                                                       : cslt_pkg::RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read answers one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= cslt_pkg::RESP_OKAY;
    end else if (ce) begin
      if (ar_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= (rd_idx == cslt_pkg::REG_NONE) ? cslt_pkg::RESP_SLVERR
                                                        : cslt_pkg::RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // register file
  // ****************************************************************
  // mask and timing writes obey byte lanes; reserved bits stay zero
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q           <= cslt_pkg::RST_IRQ[cslt_pkg::MASK_LSB +: 3];
      pend_q           <= 3'h0;
      attr_tim_q       <= cslt_pkg::RST_TIM;
      io_tim_q         <= cslt_pkg::RST_TIM;
      comm_tim_q       <= cslt_pkg::RST_TIM;
      cfg_q            <= cslt_pkg::RST_SLOT_CFG[cslt_pkg::IO_WIDE_BIT +: 4];
      disk_host_enable <= cslt_pkg::RST_DISK_CTL[cslt_pkg::ENABLE_BIT];
      clk_down_ready_q <= cslt_pkg::RST_DISK_CTL[cslt_pkg::CLKDN_BIT];
      card_irq_out     <= 1'b0;
    end else if (ce) begin
      pend_q           <= pend_d;
      card_irq_out     <= |(pend_q & ~mask_q);
      clk_down_ready_q <= disk_host_idle & ~disk_host_enable;
      if (wr_fire) begin
        case (wr_idx)
          cslt_pkg::REG_CFG:  cfg_q <= cfg_merged[cslt_pkg::IO_WIDE_BIT +: 4];
          cslt_pkg::REG_IRQ:  mask_q <= irq_merged[cslt_pkg::MASK_LSB +: 3];
          cslt_pkg::REG_ATTR: attr_tim_q <= merge(attr_tim_q, w_data_q, w_strb_q)
                                            & cslt_pkg::MASK_TIM;
          cslt_pkg::REG_IO:   io_tim_q <= merge(io_tim_q, w_data_q, w_strb_q)
                                          & cslt_pkg::MASK_TIM;
          cslt_pkg::REG_COMM: comm_tim_q <= merge(comm_tim_q, w_data_q, w_strb_q)
                                            & cslt_pkg::MASK_TIM;
          cslt_pkg::REG_DISK: if (w_strb_q[0]) disk_host_enable <= w_data_q[0];
          default:            ;
        endcase
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_mask_reset;
    @(posedge clk) disable iff (rst) $past(rst) |-> (mask_q == 3'h6 && pend_q == 3'h0);
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask reset wrong");
  property p_err_set;
    @(posedge clk) disable iff (rst) (ce && empty_err) |=> pend_q[2];
  endproperty
  a_err_set: assert property (p_err_set) else $error("empty slot error not latched");
  property p_req_set;
    @(posedge clk) disable iff (rst) (ce && irq_fall) |=> pend_q[1];
  endproperty
  a_req_set: assert property (p_req_set) else $error("card request not latched");
  property p_cd_set;
    @(posedge clk) disable iff (rst) (ce && cd_fall) |=> pend_q[0] ##1 (pend_q[0] || !ce || $past(pend_clr[0]));
  endproperty
  a_cd_set: assert property (p_cd_set) else $error("card detect not latched");
  property p_w1c;
    @(posedge clk) disable iff (rst) (ce && pend_clr[0] && !cd_fall) |=> !pend_q[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("pending not cleared by one");
  property p_tim_reset;
    @(posedge clk) disable iff (rst)
      $past(rst) |-> (attr_tim_q == 32'h0003_1909 && io_tim_q == comm_tim_q && io_tim_q == attr_tim_q);
  endproperty
  a_tim_reset: assert property (p_tim_reset) else $error("timing reset wrong");
  property p_clkdn;
    @(posedge clk) disable iff (rst) (ce && disk_host_enable) |=> !clk_down_ready_q;
  endproperty
  a_clkdn: assert property (p_clkdn) else $error("clock-down ready while enabled");
  property p_irq_out;
    @(posedge clk) disable iff (rst) ce |=> (card_irq_out == |($past(pend_q) & ~$past(mask_q)));
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("interrupt out wrong");
  c_err:  cover property (@(posedge clk) disable iff (rst) ce && empty_err);
  c_done: cover property (@(posedge clk) disable iff (rst) acc_done);
  c_irq:  cover property (@(posedge clk) disable iff (rst) card_irq_out);
  c_strobe: cover property (@(posedge clk) disable iff (rst) acc.phase == cslt_pkg::PH_STROBE);
endmodule
`default_nettype wire

// ---- cslt_card.sv ----
// card model for the slot: presence, interrupt request, wait
// assumes strobe_n comes from the slot logic on clk
`timescale 1ns/1ps
`default_nettype none
module cslt_card (
  // bench control
  input  wire logic       clk,
  input  wire logic       present,
  input  wire logic       irq_req,
  input  wire logic [3:0] wait_cyc,
  // card pins
  input  wire logic       strobe_n,
  output logic            detect_n,
  output logic            irq_n,
  output logic            wait_n
);
  int n = 0;
  // an absent card cannot request anything
  assign detect_n = !present;
  assign irq_n    = !(present && irq_req);
  // wait low for the first wait_cyc strobe cycles
  always @(posedge clk) n <= strobe_n ? 0 : n + 1;
  assign wait_n   = strobe_n || (n >= wait_cyc);
endmodule
`default_nettype wire

// ---- card_slot_timing_and_irq_test.sv ----
// self-checking bench of the slot block over its register bus
// assumes the card model and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module card_slot_timing_and_irq_test;
  logic clk = 0, rst = 1, aw = 0, w = 0, b = 0, ar = 0, r = 0, pres = 0, ireq = 0, en = 1;
  logic areq = 0, idle = 1, awr, wr_, bv, arr, rv, sn, wide, busy, done, den, irq;
  logic dn, in_, wn;
  logic [31:0] aa = 0, wd = 0, ra = 0, rdt, v;
  logic [1:0]  br, rr, rs, asp = 0;
  logic [3:0]  wc = 0;
  int errors = 0, n_tests = 0;
  always #5 clk = !clk;
  cslt_top u_cslt_top (.clk(clk), .rst(rst), .ce(en), .s_axi_awaddr(aa),
    .s_axi_awvalid(aw), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(w), .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(b), .s_axi_araddr(ra), .s_axi_arvalid(ar), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(r),
    .card_detect_in_n(dn), .card_irq_in_n(in_), .card_wait_in_n(wn),
    .card_strobe_n(sn), .card_wide(wide), .acc_req(areq), .acc_space(asp),
    .acc_busy(busy), .acc_done(done), .disk_host_idle(idle),
    .disk_host_enable(den), .card_irq_out(irq));
  cslt_card u_cslt_card (.clk(clk), .present(pres), .irq_req(ireq), .wait_cyc(wc),
    .strobe_n(sn), .detect_n(dn), .irq_n(in_), .wait_n(wn));
  // ****************************************************************
  // bus tasks
  // ****************************************************************
  task automatic wr(input logic [31:0] a, d);
    aa <= a; wd <= d; aw <= 1; w <= 1; b <= 1;
    do begin @(posedge clk); if (awr) aw <= 0; if (wr_) w <= 0; end while (bv !== 1'b1);
    rs = br;
  endtask
  // ready stays high between transfers, so no strobe is dropped and raised in one step
  task automatic rd(input logic [31:0] a);
    ra <= a; ar <= 1; r <= 1;
    do begin @(posedge clk); if (arr) ar <= 0; end while (rv !== 1'b1);
    v = rdt; rs = rr;
  endtask
  task automatic rc(input logic [31:0] a, e);
    rd(a); `CK("reg", e, v)
  endtask
  // counts busy and strobe cycles of one access
  task automatic acc(input logic [1:0] s, input int eb, es);
    logic [31:0] nb, ns;
    nb = 0; ns = 0; asp <= s; areq <= 1; @(posedge clk); areq <= 0;
    repeat (300) begin @(posedge clk); nb += busy; ns += !sn; if (done) break; end
    `CK("busy", eb, nb) `CK("strobe", es, ns)
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_irq();
    rc(cslt_pkg::ADDR_IRQ, 32'h0000_0600);
    areq <= 1; @(posedge clk); areq <= 0; repeat (3) @(posedge clk);
    rc(cslt_pkg::ADDR_IRQ, 32'h0000_0604); `CK("irq", 1'b0, irq)
    wr(cslt_pkg::ADDR_IRQ, 32'h0000_0200); rc(cslt_pkg::ADDR_IRQ, 32'h0000_0204);
    `CK("irq", 1'b1, irq)
    wr(cslt_pkg::ADDR_IRQ, 32'h0000_0604); rc(cslt_pkg::ADDR_IRQ, 32'h0000_0600);
    pres <= 1; repeat (6) @(posedge clk);
    rc(cslt_pkg::ADDR_IRQ, 32'h0000_0601); `CK("irq", 1'b1, irq)
    wr(cslt_pkg::ADDR_IRQ, 32'h0000_0601); rc(cslt_pkg::ADDR_IRQ, 32'h0000_0600);
    ireq <= 1; repeat (6) @(posedge clk);
    rc(cslt_pkg::ADDR_IRQ, 32'h0000_0602); `CK("irq", 1'b0, irq)
    wr(cslt_pkg::ADDR_IRQ, 32'h0000_0602); rc(cslt_pkg::ADDR_IRQ, 32'h0000_0600);
    $display("interrupt test done");
  endtask
  task automatic t_timing();
    rc(cslt_pkg::ADDR_ATTR_TIM, 32'h0003_1909); rc(cslt_pkg::ADDR_COMM_TIM, 32'h0003_1909);
    rc(cslt_pkg::ADDR_IO_TIM, 32'h0003_1909);
    rc(cslt_pkg::ADDR_SLOT_CFG, 32'h0000_0F04);
    wr(cslt_pkg::ADDR_IO_TIM, 32'hFF01_0302); `CK("bresp", 2'h0, rs)
    rc(cslt_pkg::ADDR_IO_TIM, 32'h0001_0302);
    acc(2'h1, 9, 4);
    wc <= 4'h2; acc(2'h1, 11, 6);
    wr(32'h4B80_1820, 32'h0000_0300); acc(2'h1, 9, 4);
    acc(2'h0, 40, 26); `CK("wide", 1'b0, wide)
    acc(2'h2, 40, 26); `CK("wide", 1'b1, wide)
    acc(2'h3, 40, 26); `CK("wide", 1'b1, wide)
    wr(32'h4B80_1834, 32'h0); `CK("bresp", 2'h2, rs)
    rd(32'h4B80_1834); `CK("resp", 2'h2, rs)
    // a request while the enable is low must not start an access
    en <= 0; areq <= 1; @(posedge clk); areq <= 0; repeat (3) @(posedge clk);
    `CK("frozen", 1'b0, busy)
    en <= 1;
    $display("timing test done");
  endtask
  task automatic t_disk();
    rc(cslt_pkg::ADDR_DISK_CTL, 32'h0000_0002);
    wr(cslt_pkg::ADDR_DISK_CTL, 32'h0000_0001); `CK("en", 1'b1, den)
    rc(cslt_pkg::ADDR_DISK_CTL, 32'h0000_0001);
    wr(cslt_pkg::ADDR_DISK_CTL, 32'h0000_0000);
    rc(cslt_pkg::ADDR_DISK_CTL, 32'h0000_0002);
    // ready lags the idle input by one cycle, so let an edge pass first
    idle <= 0; @(posedge clk);
    rc(cslt_pkg::ADDR_DISK_CTL, 32'h0000_0000);
    $display("disk host test done");
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence and watchdog
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    t_irq(); t_timing(); t_disk();
    end_of_test();
  end
  initial begin #200000; errors++; end_of_test(); end
endmodule
`default_nettype wire
